/* hdl/bus_lock_queue_status_ctrl.v */
// bus lock, hold arbitration, nmi, queue report, read strobe and peripheral selects
`timescale 1ns/1ns
`include "bus_lock_queue_status_regs.vh"
module bus_lock_queue_status_ctrl (
	input wire CORE_CLK,
	input wire RST_N,
	input wire CYC_ACTIVE,
	input wire [1:0] CYC_KIND,
	input wire CYC_LOCKED,
	input wire CYC_ALE,
	input wire [`PSEL_COUNT-1:0] CYC_REGION_HIT,
	input wire Q_FIRST,
	input wire Q_NEXT,
	input wire Q_FLUSH,
	input wire HOLD,
	input wire NMI,
	input wire QSMD_IN,
	output reg HLDA,
	output reg NMI_REQ,
	output wire [7:0] NMI_VECTOR_TYPE,
	output wire LOCK_N_O,
	output wire LOCK_N_OE,
	output wire LOCK_PULLUP,
	output reg RD_N,
	output wire ALE_QS0,
	output wire WR_N_QS1,
	output wire RD_N_OE,
	output wire QUEUE_MODE,
	output reg periph_select_0,
	output reg periph_select_1,
	output reg periph_select_2,
	output reg periph_select_3,
	output reg periph_select_4,
	output reg periph_select_5,
	output reg periph_select_6
);
	// registered state and next values
	reg in_reset_q;
	reg lock_q;
	reg lock_d;
	reg hlda_d;
	reg nmi_req_d;
	reg qmode_q;
	reg qmode_d;
	reg rd_n_d;
	reg wr_n_q;
	reg wr_n_d;
	reg ale_q;
	reg ale_d;
	reg [1:0] qrep_q;
	reg [1:0] qrep_d;
	reg [`PSEL_COUNT-1:0] psel_n_q;
	wire [`PSEL_COUNT-1:0] psel_n_d;
	wire locked_now;
	wire read_now;
	wire write_now;
	wire [2:0] q_events;

	// decoded view of the cycle now on the bus
	assign locked_now = CYC_ACTIVE & CYC_LOCKED;
	assign read_now = CYC_ACTIVE & (CYC_KIND == `CYC_READ);
	assign write_now = CYC_ACTIVE & (CYC_KIND == `CYC_WRITE);
	assign q_events = {Q_FLUSH, Q_FIRST, Q_NEXT};

	// reset tracker, high in reset and up to the first edge after it
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			in_reset_q <= 1'b1;
		end else begin
			in_reset_q <= 1'b0;
		end
	end

	// lock follows a locked cycle one edge later
	always @* begin
		lock_d = locked_now;
	end

	// lock register, cleared by reset
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			lock_q <= 1'b0;
		end else begin
			lock_q <= lock_d;
		end
	end

	// lock pin value, drive enable and weak keeper
	assign LOCK_N_O = ~lock_q;
	assign LOCK_N_OE = ~in_reset_q; // pin released while in reset
	assign LOCK_PULLUP = 1'b1; // weak keeper, always on

	// grant waits until neither the lock register nor the live cycle is locked
	always @* begin
		hlda_d = 1'b0;
		if (HOLD) begin
			if (HLDA) begin
				hlda_d = 1'b1; // grant stands until hold drops
			end else if (!lock_q && !locked_now) begin
				hlda_d = 1'b1;
			end
		end
	end

	// hold acknowledge register
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HLDA <= 1'b0;
		end else begin
			HLDA <= hlda_d;
		end
	end

	// nmi is never masked here
	always @* begin
		nmi_req_d = NMI;
	end

	// nmi request register
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			NMI_REQ <= 1'b0;
		end else begin
			NMI_REQ <= nmi_req_d;
		end
	end
	assign NMI_VECTOR_TYPE = `NMI_TYPE; // fixed type 2

	// mode pin taken on every edge while reset is held, low selects queue mode
	always @* begin
		qmode_d = qmode_q;
		if (in_reset_q) begin
			qmode_d = ~QSMD_IN;
		end
	end

	// mode register has no reset, it must load while reset is held
	always @(posedge CORE_CLK) begin
		qmode_q <= qmode_d;
	end
	assign QUEUE_MODE = qmode_q;
	assign RD_N_OE = ~in_reset_q & ~qmode_q; // pin is the mode input in reset

	// queue event encoding, flush over first over next
	always @* begin
		case (q_events)
			3'h0: qrep_d = `QREP_NONE;
			3'h1: qrep_d = `QREP_NEXT;
			3'h2, 3'h3: qrep_d = `QREP_FIRST;
			default: qrep_d = `QREP_FLUSH;
		endcase
	end

	// read strobe low through read cycles
	always @* begin
		rd_n_d = ~read_now;
	end

	// read strobe register
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			RD_N <= 1'b1;
		end else begin
			RD_N <= rd_n_d;
		end
	end

	// write strobe and address latch next values
	always @* begin
		wr_n_d = ~write_now;
		ale_d = CYC_ALE;
	end

	// write strobe and address latch registers
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_n_q <= 1'b1;
			ale_q <= 1'b0;
		end else begin
			wr_n_q <= wr_n_d;
			ale_q <= ale_d;
		end
	end

	// queue report register
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			qrep_q <= `QREP_NONE;
		end else begin
			qrep_q <= qrep_d;
		end
	end

	// shared pins carry queue bits in queue mode
	assign ALE_QS0 = qmode_q ? qrep_q[0] : ale_q;
	assign WR_N_QS1 = qmode_q ? qrep_q[1] : wr_n_q;

	// peripheral selects, one register per region
	genvar i;
	generate
		for (i = 0; i < `PSEL_COUNT; i = i + 1) begin : g_psel
			assign psel_n_d[i] = ~(CYC_ACTIVE & CYC_REGION_HIT[i]);
			always @(posedge CORE_CLK or negedge RST_N) begin
				if (!RST_N) begin
					psel_n_q[i] <= 1'b1;
				end else begin
					psel_n_q[i] <= psel_n_d[i];
				end
			end
		end
	endgenerate

	// select registers onto the output pins
	always @* begin
		periph_select_0 = psel_n_q[0];
		periph_select_1 = psel_n_q[1];
		periph_select_2 = psel_n_q[2];
		periph_select_3 = psel_n_q[3];
		periph_select_4 = psel_n_q[4];
		periph_select_5 = psel_n_q[5];
		periph_select_6 = psel_n_q[6];
	end
endmodule // bus_lock_queue_status_ctrl

/* hdl/bus_lock_queue_status_regs.vh */
// constants for the bus lock and queue status control block
`ifndef BUS_LOCK_QUEUE_STATUS_REGS_VH
`define BUS_LOCK_QUEUE_STATUS_REGS_VH
// queue report codes, bit1 bit0
`define QREP_NONE 2'h0
`define QREP_FIRST 2'h1
`define QREP_FLUSH 2'h2
`define QREP_NEXT 2'h3
// nmi interrupt type
`define NMI_TYPE 8'h02
// number of peripheral selects
`define PSEL_COUNT 7
// bus cycle kinds
`define CYC_READ 2'h1
`define CYC_WRITE 2'h2
`endif

/* verification/bus_far_side.sv */
// far side: lock pin wire and a memory answering reads
`timescale 1ns/1ns
module bus_far_side (
	input wire RD_N, LOCK_N_O, LOCK_N_OE, LOCK_PULLUP,
	output wire lock_pin,
	output wire [7:0] data_bus
);
	// driven value or weak pull, never pulled low from outside
	assign lock_pin = LOCK_N_OE ? LOCK_N_O : LOCK_PULLUP;
	// location data while read is low, inverse otherwise
	assign data_bus = !RD_N ? 8'hA5 : 8'h5A;
endmodule // bus_far_side

/* verification/bus_lock_monitor.sv */
// checker for the lock, hold, nmi, queue report, read strobe and periph_select_0 outputs
`timescale 1ns/1ns
module bus_lock_monitor (
	input wire CORE_CLK, RST_N, CYC_ACTIVE, CYC_LOCKED, Q_FIRST, Q_FLUSH, HOLD, NMI,
	input wire [1:0] CYC_KIND,
	input wire [6:0] CYC_REGION_HIT,
	input wire [7:0] NMI_VECTOR_TYPE,
	input wire QSMD_IN, HLDA, NMI_REQ, LOCK_N_O, LOCK_N_OE, LOCK_PULLUP, RD_N,
	input wire ALE_QS0, WR_N_QS1, QUEUE_MODE, periph_select_0
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	sequence locked_cyc; CYC_ACTIVE && CYC_LOCKED; endsequence
	chk_lock_drive: assert property (locked_cyc |=> !LOCK_N_O) else $error("lock high");
	chk_hold_defer: assert property ($rose(HLDA) |-> $past(LOCK_N_O) && $past(HOLD)) else $error("bad grant");
	chk_reset_float: assert property (disable iff (1'b0) !RST_N |-> !LOCK_N_OE && LOCK_PULLUP) else $error("lock driven");
	chk_nmi_type: assert property (NMI |=> NMI_REQ && NMI_VECTOR_TYPE == 8'h02) else $error("nmi");
	chk_queue_first: assert property (QUEUE_MODE && Q_FIRST && !Q_FLUSH |=> {WR_N_QS1, ALE_QS0} == 2'h1) else $error("first");
	chk_queue_flush: assert property (QUEUE_MODE && Q_FLUSH |=> {WR_N_QS1, ALE_QS0} == 2'h2) else $error("flush");
	chk_mode_sample: assert property ($rose(RST_N) |=> QUEUE_MODE == !QSMD_IN) else $error("mode");
	chk_read_low: assert property (CYC_ACTIVE && CYC_KIND == 2'h1 |=> !RD_N) else $error("read");
	chk_select_hit: assert property (CYC_ACTIVE && CYC_REGION_HIT[0] |=> !periph_select_0) else $error("select");
endmodule // bus_lock_monitor
bind bus_lock_queue_status_ctrl bus_lock_monitor i_mon(.*);

/* verification/bus_lock_queue_status_ctrl_test.sv */
// random bench for the bus lock and queue report block
`timescale 1ns/1ns
module bus_lock_queue_status_ctrl_test;
	// clock starts high so the first edge falls and reset gets a real edge there
	reg CORE_CLK = 1, RST_N = 1, CYC_ACTIVE = 0, CYC_LOCKED = 0, CYC_ALE = 0, HOLD = 0, NMI = 0;
	reg exp_lock = 0, exp_hlda = 0;
	reg Q_FIRST = 0, Q_NEXT = 0, Q_FLUSH = 0, QSMD_IN = 1;
	reg [1:0] CYC_KIND = 0;
	reg [6:0] CYC_REGION_HIT = 0;
	wire HLDA, NMI_REQ, LOCK_N_O, LOCK_N_OE, LOCK_PULLUP, RD_N, ALE_QS0, WR_N_QS1, RD_N_OE;
	wire QUEUE_MODE, lock_pin, periph_select_0, periph_select_1, periph_select_2;
	wire periph_select_3, periph_select_4, periph_select_5, periph_select_6;
	wire [7:0] NMI_VECTOR_TYPE, data_bus;
	wire [6:0] sel = {periph_select_6, periph_select_5, periph_select_4, periph_select_3,
		periph_select_2, periph_select_1, periph_select_0};
	wire [21:0] outs = {HLDA, lock_pin, RD_N_OE, RD_N, NMI_REQ, WR_N_QS1, ALE_QS0, sel, data_bus};
	reg [21:0] exp_q[$];
	integer mismatches = 0, checked = 0, cycles = 0, seed;
	always #10 CORE_CLK = ~CORE_CLK;
	bus_lock_queue_status_ctrl i_dut(.*);
	bus_far_side i_far(.*);
	task check(input [47:0] name, input [21:0] e, input [21:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("mismatch %0s expected %h seen %h", name, e, g);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checked %0d mismatches %0d", checked, mismatches);
			if (mismatches == 0 && checked > 0) $display("No errors found");
			else $display("Errors were found");
			$finish;
		end
	endtask
	// random cycle; expected outputs noted for the next edge
	task step(input qm);
		reg [1:0] q;
		reg rd_e;
		begin
			@(negedge CORE_CLK);
			{CYC_ACTIVE, CYC_LOCKED, CYC_ALE, HOLD, NMI} = $urandom;
			CYC_KIND = $urandom % 3;
			CYC_REGION_HIT = CYC_ACTIVE ? 7'h01 << ($urandom % 8) : 7'h00;
			q = $urandom % 4;
			{Q_FLUSH, Q_FIRST, Q_NEXT} = q ? 3'h1 << (q - 1) : 3'h0;
			rd_e = !(CYC_ACTIVE && CYC_KIND == 2'h1);
			// grant model: waits for both the previous and the live cycle to be unlocked
			exp_hlda = HOLD && (exp_hlda || (!exp_lock && !(CYC_ACTIVE && CYC_LOCKED)));
			exp_lock = CYC_ACTIVE && CYC_LOCKED;
			exp_q.push_back({exp_hlda, !exp_lock, !qm, rd_e, NMI, qm ? (Q_FLUSH ? 2'h2 :
				Q_FIRST ? 2'h1 : Q_NEXT ? 2'h3 : 2'h0) : {!(CYC_ACTIVE && CYC_KIND == 2'h2),
				CYC_ALE}, ~CYC_REGION_HIT, rd_e ? 8'h5A : 8'hA5});
		end
	endtask
	task run(input qm);
		integer i;
		begin
			@(negedge CORE_CLK);
			exp_lock = 0;
			exp_hlda = 0;
			{CYC_ACTIVE, CYC_LOCKED, CYC_ALE, HOLD, NMI, Q_FIRST, Q_NEXT, Q_FLUSH} = 8'h00;
			CYC_REGION_HIT = 7'h00;
			RST_N = 0;
			QSMD_IN = !qm;
			repeat (8) @(negedge CORE_CLK);
			check("reset", 11'h37F, {LOCK_N_OE, lock_pin, RD_N, HLDA, sel});
			RST_N = 1;
			@(negedge CORE_CLK);
			check("mode", qm, QUEUE_MODE);
			for (i = 0; i < 300; i = i + 1) step(qm);
			@(negedge CORE_CLK);
			$display("test done, queue mode %0d", qm);
		end
	endtask
	// watcher: oldest note against the settled outputs
	always @(posedge CORE_CLK) begin
		#1 cycles = cycles + 1;
		if (exp_q.size() > 0) begin
			check("outs", exp_q.pop_front(), outs);
		end
		if (cycles == 2000) begin
			mismatches = mismatches + 1;
			finish_test;
		end
	end
	initial begin
		seed = $urandom(12);
		run(0);
		run(1);
		finish_test;
	end
endmodule // bus_lock_queue_status_ctrl_test
